// ==== common/dds_defines.vh ====
// Overview of operation
// - Every serial transfer is one 16-bit word clocked by the host serial clock.
// - Serial data is accepted only while frame select is held low.
// - One bit is captured per serial clock falling edge, sixteen per word.
// - Frame select held low longer yields one word per sixteen bits.
// - Reset bit zeroes accumulator and pipeline, keeping frequency, phase, control contents.
// - Output data appears eight master clock cycles after reset clears.
// - A loaded frequency word reaches the output after seven cycles, a phase word after six.
// - All control fields except waveform mode, full-word and upper-half select pass a sampling stage first.
// - Top bits 00 write the remaining 14 bits to the control register.
// - Full-word mode loads a frequency register by low half then high half.
// - Full-word mode commits the frequency register only after both halves.
// - Half-word mode updates each 14-bit frequency half independently.
// - Upper-half select picks high or low half; ignored in full-word mode.
// - Frequency choice bit picks which frequency register drives the accumulator.
// - Phase choice bit picks which phase offset is added to the accumulator.
// - Control bit 8 high holds internal state at zero; low releases it.
// - Clock sleep bit 7 freezes accumulator and output; clearing restarts them.
`ifndef DDS_DEFINES_VH
`define DDS_DEFINES_VH

// ****************************************
// Word layout
// ****************************************
`define DDS_WORD_BITS      16
`define DDS_ADDR_HI        15
`define DDS_ADDR_LO        14
`define DDS_ADDR_CTRL      2'h0
`define DDS_ADDR_FREQ_A    2'h1
`define DDS_ADDR_FREQ_B    2'h2
`define DDS_ADDR_PHASE     2'h3
`define DDS_PHASE_SEL_BIT  13

// ****************************************
// Control register fields
// ****************************************
`define DDS_CTL_FULL_WORD  13
`define DDS_CTL_UPPER_HALF 12
`define DDS_CTL_FREQ_SEL   11
`define DDS_CTL_PHASE_SEL  10
`define DDS_CTL_RESERVED   9
`define DDS_CTL_RESET      8
`define DDS_CTL_SLEEP      7
`define DDS_CTL_MODE       1
`define DDS_CTL_RESET_VAL  14'h0000

// ****************************************
// Datapath sizes and timing
// ****************************************
`define DDS_ACC_BITS       28
`define DDS_PHASE_BITS     12
`define DDS_PIPE_STAGES    5
`define DDS_BIT_LAST       4'hf
`define DDS_FIFO_DEPTH     16
`define DDS_FIFO_AW        4

`endif

// ==== hdl/dds_fifo.v ====
`timescale 1ns/1ps
`default_nettype none
module dds_fifo #(
   parameter WIDTH = 16,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   // Clock and control
   input  wire             clk,
   input  wire             rst_n,
   input  wire             clkEn,
   // Fill side
   input  wire             inValid,
   output wire             inReady,
   input  wire [WIDTH-1:0] inData,
   // Drain side
   output wire             outValid,
   input  wire             outReady,
   output wire [WIDTH-1:0] outData
);

   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wrPtr_reg;
   reg [AW-1:0]    rdPtr_reg;
   reg [AW:0]      count_reg;
   wire            doPush;
   wire            doPop;

   assign inReady  = (count_reg != DEPTH[AW:0]);
   assign outValid = (count_reg != {(AW+1){1'b0}});
   assign outData  = mem[rdPtr_reg];
   assign doPush   = clkEn & inValid & inReady;
   assign doPop    = clkEn & outValid & outReady;

   // Storage carries no reset so it maps to plain memory
   always @(posedge clk) begin
      if (doPush) begin
         mem[wrPtr_reg] <= inData;
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wrPtr_reg <= {AW{1'b0}};
         rdPtr_reg <= {AW{1'b0}};
         count_reg <= {(AW+1){1'b0}};
      end else begin
         if (doPush) begin
            wrPtr_reg <= wrPtr_reg + 1'b1;
         end
         if (doPop) begin
            rdPtr_reg <= rdPtr_reg + 1'b1;
         end
         if (doPush & ~doPop) begin
            count_reg <= count_reg + 1'b1;
         end else if (doPop & ~doPush) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end

endmodule
`default_nettype wire

// ==== hdl/dds_serial_load.v ====
`timescale 1ns/1ps
`default_nettype none
`include "dds_defines.vh"
module dds_serial_load (
   // Clock, reset and enable
   input  wire        clk_sys,
   input  wire        rst_n,
   input  wire        clkEn,
   // Serial load pins
   input  wire        sclk,
   input  wire        frame_select_n,
   input  wire        sdata,
   // Status
   output wire        loadReady,
   output wire [13:0] controlWord,
   output wire        waveMode,
   output wire        resetActive,
   // Generated phase towards the waveform stage
   output wire [11:0] phaseOut
);

   // ****************************************
   // Pin synchronisers
   // ****************************************
   reg        sclkMeta_reg;
   reg        sclkSync_reg;
   reg        sclkLast_reg;
   reg        fsMeta_reg;
   reg        fsSync_reg;
   reg        sdMeta_reg;
   reg        sdSync_reg;
   wire       sclkFall;
   wire       frameOn;

   // Only the second stage and later are looked at
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sclkMeta_reg <= 1'b1;
         sclkSync_reg <= 1'b1;
         sclkLast_reg <= 1'b1;
         fsMeta_reg   <= 1'b1;
         fsSync_reg   <= 1'b1;
         sdMeta_reg   <= 1'b0;
         sdSync_reg   <= 1'b0;
      end else if (clkEn) begin
         sclkMeta_reg <= sclk;
         sclkSync_reg <= sclkMeta_reg;
         sclkLast_reg <= sclkSync_reg;
         fsMeta_reg   <= frame_select_n;
         fsSync_reg   <= fsMeta_reg;
         sdMeta_reg   <= sdata;
         sdSync_reg   <= sdMeta_reg;
      end
   end

   // Clock and frame synchronisers reset to the idle-high level of the pins, so no false edge follows reset
   assign sclkFall = sclkLast_reg & ~sclkSync_reg;
   assign frameOn  = ~fsSync_reg;

   // ****************************************
   // Input shift register
   // ****************************************
   // Fifteen bits wait here; the sixteenth joins them as the word is handed over
   reg [14:0] shift_reg;
   reg [3:0]  bitCnt_reg;
   reg        wordValid_reg;
   reg [15:0] wordData_reg;

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         shift_reg     <= 15'h0000;
         bitCnt_reg    <= 4'h0;
         wordValid_reg <= 1'b0;
         wordData_reg  <= 16'h0000;
      end else if (clkEn) begin
         wordValid_reg <= 1'b0;
         if (!frameOn) begin
            bitCnt_reg <= 4'h0;
         end else if (sclkFall) begin
            shift_reg  <= {shift_reg[13:0], sdSync_reg};
            bitCnt_reg <= bitCnt_reg + 4'h1;
            if (bitCnt_reg == `DDS_BIT_LAST) begin
               wordValid_reg <= 1'b1;
               wordData_reg  <= {shift_reg, sdSync_reg};
            end
         end
      end
   end

   // ****************************************
   // Word buffer
   // ****************************************
   wire        fifoOutValid;
   wire        fifoOutReady;
   wire [15:0] fifoOutData;

   // The serial side cannot stall, so a full buffer drops words and says so on loadReady
   dds_fifo #(
      .WIDTH (`DDS_WORD_BITS),
      .DEPTH (`DDS_FIFO_DEPTH),
      .AW    (`DDS_FIFO_AW)
   ) dds_fifo_inst (
      .clk      (clk_sys),
      .rst_n    (rst_n),
      .clkEn    (clkEn),
      .inValid  (wordValid_reg),
      .inReady  (loadReady),
      .inData   (wordData_reg),
      .outValid (fifoOutValid),
      .outReady (fifoOutReady),
      .outData  (fifoOutData)
   );

   // ****************************************
   // Word decoder
   // ****************************************
   reg        decBusy_reg;
   reg [15:0] dec_reg;
   reg [13:0] ctl_reg;
   reg [13:0] ctlLive_reg;
   reg [27:0] freqA_reg;
   reg [27:0] freqB_reg;
   reg [11:0] phaseA_reg;
   reg [11:0] phaseB_reg;
   reg [13:0] pendLow_reg;
   reg [1:0]  pendAddr_reg;
   reg        pendValid_reg;
   wire [1:0] decAddr;
   wire [13:0] decData;

   function isFreqB;
      input [1:0] addr;
      begin
         isFreqB = (addr == `DDS_ADDR_FREQ_B);
      end
   endfunction

   // Each word takes two cycles so the buffer can really back up
   assign fifoOutReady = ~decBusy_reg;
   assign decAddr      = dec_reg[`DDS_ADDR_HI:`DDS_ADDR_LO];
   assign decData      = dec_reg[13:0];

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         decBusy_reg   <= 1'b0;
         dec_reg       <= 16'h0000;
         ctl_reg       <= `DDS_CTL_RESET_VAL;
         freqA_reg     <= 28'h0000000;
         freqB_reg     <= 28'h0000000;
         phaseA_reg    <= 12'h000;
         phaseB_reg    <= 12'h000;
         pendLow_reg   <= 14'h0000;
         pendAddr_reg  <= 2'h0;
         pendValid_reg <= 1'b0;
      end else if (clkEn) begin
         if (!decBusy_reg) begin
            if (fifoOutValid) begin
               dec_reg     <= fifoOutData;
               decBusy_reg <= 1'b1;
            end
         end else begin
            decBusy_reg <= 1'b0;
            case (decAddr)
               `DDS_ADDR_CTRL: begin
                  ctl_reg       <= decData;
                  pendValid_reg <= 1'b0;
               end
               `DDS_ADDR_FREQ_A, `DDS_ADDR_FREQ_B: begin
                  if (ctl_reg[`DDS_CTL_FULL_WORD]) begin
                     if (pendValid_reg && (pendAddr_reg == decAddr)) begin
                        // Whole word commits at once, never half old and half new
                        if (isFreqB(decAddr)) begin
                           freqB_reg <= {decData, pendLow_reg};
                        end else begin
                           freqA_reg <= {decData, pendLow_reg};
                        end
                        pendValid_reg <= 1'b0;
                     end else begin
                        pendLow_reg   <= decData;
                        pendAddr_reg  <= decAddr;
                        pendValid_reg <= 1'b1;
                     end
                  end else begin
                     pendValid_reg <= 1'b0;
                     if (ctl_reg[`DDS_CTL_UPPER_HALF]) begin
                        if (isFreqB(decAddr)) begin
                           freqB_reg[27:14] <= decData;
                        end else begin
                           freqA_reg[27:14] <= decData;
                        end
                     end else begin
                        if (isFreqB(decAddr)) begin
                           freqB_reg[13:0] <= decData;
                        end else begin
                           freqA_reg[13:0] <= decData;
                        end
                     end
                  end
               end
               `DDS_ADDR_PHASE: begin
                  // Any other address between the two halves restarts the pair
                  pendValid_reg <= 1'b0;
                  if (dec_reg[`DDS_PHASE_SEL_BIT]) begin
                     phaseB_reg <= dec_reg[11:0];
                  end else begin
                     phaseA_reg <= dec_reg[11:0];
                  end
               end
               default: begin
                  pendValid_reg <= pendValid_reg;
               end
            endcase
         end
      end
   end

   // ****************************************
   // Control sampling
   // ****************************************
   // One stage of sampling keeps a half-applied control word out of the datapath
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ctlLive_reg <= `DDS_CTL_RESET_VAL;
      end else if (clkEn) begin
         ctlLive_reg <= ctl_reg;
      end
   end

   // ****************************************
   // Accumulator and phase offset
   // ****************************************
   reg  [27:0] acc_reg;
   reg  [11:0] sum_reg;
   reg         runLast_reg;
   wire [27:0] freqSel;
   wire [11:0] phaseSel;
   wire        holdReset;
   wire        sleeping;

   assign freqSel   = ctlLive_reg[`DDS_CTL_FREQ_SEL] ? freqB_reg : freqA_reg;
   assign phaseSel  = ctlLive_reg[`DDS_CTL_PHASE_SEL] ? phaseB_reg : phaseA_reg;
   assign holdReset = ctlLive_reg[`DDS_CTL_RESET];
   assign sleeping  = ctlLive_reg[`DDS_CTL_SLEEP];

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         acc_reg     <= 28'h0000000;
         sum_reg     <= 12'h000;
         runLast_reg <= 1'b0;
      end else if (clkEn) begin
         if (holdReset) begin
            acc_reg     <= 28'h0000000;
            sum_reg     <= 12'h000;
            runLast_reg <= 1'b0;
         end else if (!sleeping) begin
            acc_reg     <= acc_reg + freqSel;
            runLast_reg <= 1'b1;
            // The first cycle after release still shows zero, so an offset cannot beat the release latency
            if (runLast_reg) begin
               sum_reg <= acc_reg[27:16] + phaseSel;
            end else begin
               sum_reg <= 12'h000;
            end
         end
      end
   end

   // Five delay stages set the load-to-output and reset-to-output latency
   // Stages meet in one flat bus so that every stage register has a single driver
   wire [12*(`DDS_PIPE_STAGES+1)-1:0] pipeChain;
   assign pipeChain[11:0] = sum_reg;
   genvar gi;
   generate
      for (gi = 0; gi < `DDS_PIPE_STAGES; gi = gi + 1) begin : g_pipe
         reg [11:0] stage_reg;
         always @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
               stage_reg <= 12'h000;
            end else if (clkEn) begin
               if (holdReset) begin
                  stage_reg <= 12'h000;
               end else if (!sleeping) begin
                  stage_reg <= pipeChain[12*gi +: 12];
               end
            end
         end
         assign pipeChain[12*(gi+1) +: 12] = stage_reg;
      end
   endgenerate

   // ****************************************
   // Outputs
   // ****************************************
   assign phaseOut    = pipeChain[12*`DDS_PIPE_STAGES +: 12];
   // The register as written, one stage ahead of what the datapath uses
   assign controlWord = ctl_reg;
   // Mode bypasses the sampling stage
   assign waveMode    = ctl_reg[`DDS_CTL_MODE];
   assign resetActive = ctlLive_reg[`DDS_CTL_RESET];

endmodule
`default_nettype wire

// ==== test/dds_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module dds_host_model (
   // Serial load pins
   output var logic sclk,
   output var logic frame_select_n,
   output var logic sdata
);
   initial begin
      sclk = 1'b1;
      frame_select_n = 1'b1;
      sdata = 1'b0;
   end
   // One frame, MSB first; cut below 16 ends the last word early
   task automatic xfer(input logic [15:0] words [$], input int cut);
      int nb;
      frame_select_n = 1'b0;
      #62.5;
      for (int k = 0; k < words.size(); k++) begin
         nb = (k == words.size() - 1) ? cut : 16;
         for (int i = 15; i > 15 - nb; i--) begin
            sdata = words[k][i];
            #31.25;
            sclk = 1'b0;
            #62.5;
            sclk = 1'b1;
            #31.25;
         end
      end
      frame_select_n = 1'b1;
      // Released line: show the inverse rather than a stale value
      sdata = ~sdata;
      // Frame stays high for a while so that back-to-back frames are seen apart
      #62.5;
   endtask
endmodule
`default_nettype wire

// ==== test/dds_serial_load_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
// ********
// Port checker
// ********
module dds_serial_load_asserts (
   // Clock and reset
   input wire logic        clk_sys,
   input wire logic        rst_n,
   // Inputs
   input wire logic        clkEn,
   input wire logic        frame_select_n,
   // Outputs
   input wire logic        loadReady,
   input wire logic [13:0] controlWord,
   input wire logic        waveMode,
   input wire logic        resetActive,
   input wire logic [11:0] phaseOut
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   logic [5:0] idleCnt;
   // Frame idle long enough that every queued word has drained
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n)
         idleCnt <= 6'h00;
      else if (!frame_select_n)
         idleCnt <= 6'h00;
      else if (idleCnt != 6'h3f)
         idleCnt <= idleCnt + 6'h01;
   end
   sequence s_release;
      $fell(controlWord[8]) && resetActive;
   endsequence
   sequence s_asleep;
      controlWord[7] && $past(controlWord[7]) && !resetActive;
   endsequence
   a_ctl_sampled: assert property ($past(clkEn) |-> resetActive == $past(controlWord[8]))
      else $error("resetActive does not follow control bit 8 by one cycle");
   a_mode_direct: assert property (waveMode == controlWord[1])
      else $error("waveMode differs from control bit 1");
   a_reset_zero: assert property ((resetActive && clkEn)[*8] |=> phaseOut == 12'h000)
      else $error("phaseOut not zero while soft reset held");
   a_release_latency: assert property (s_release |-> (phaseOut == 12'h000)[*8])
      else $error("phaseOut moved before eight cycles after release");
   a_sleep_hold: assert property (s_asleep |=> $stable(phaseOut))
      else $error("phaseOut moved while asleep");
   a_clk_freeze: assert property (!clkEn |=> $stable(phaseOut) && $stable(controlWord))
      else $error("outputs moved with clock stopped");
   a_idle_ctl_stable: assert property (idleCnt > 6'h28 |-> $stable(controlWord))
      else $error("controlWord changed with no frame");
   a_idle_fifo_empty: assert property (idleCnt > 6'h28 |-> loadReady)
      else $error("no room reported after long idle");
endmodule
bind dds_serial_load dds_serial_load_asserts dds_serial_load_asserts_inst (.clk_sys(clk_sys), .rst_n(rst_n),
   .clkEn(clkEn), .frame_select_n(frame_select_n), .loadReady(loadReady), .controlWord(controlWord),
   .waveMode(waveMode), .resetActive(resetActive), .phaseOut(phaseOut));
`default_nettype wire

// ==== test/test_dds_serial_control_load.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_dds_serial_control_load;
   logic        clk_sys;
   logic        rst_n;
   logic        clkEn;
   wire         sclk;
   wire         frame_select_n;
   wire         sdata;
   wire         loadReady;
   wire  [13:0] controlWord;
   wire         waveMode;
   wire         resetActive;
   wire  [11:0] phaseOut;
   logic [15:0] q [$];
   logic [11:0] p;
   int          nFail;
   int          testsRun;
   dds_serial_load dds_serial_load_inst (.clk_sys(clk_sys), .rst_n(rst_n), .clkEn(clkEn), .sclk(sclk),
      .frame_select_n(frame_select_n), .sdata(sdata), .loadReady(loadReady), .controlWord(controlWord),
      .waveMode(waveMode), .resetActive(resetActive), .phaseOut(phaseOut));
   dds_host_model dds_host_model_inst (.sclk(sclk), .frame_select_n(frame_select_n), .sdata(sdata));
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   // ********
   // Helpers
   // ********
   task automatic tallyAndFinish;
      $display("Checks %0d, mismatches %0d", testsRun, nFail);
      if (nFail == 0 && testsRun > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [13:0] exp, input logic [13:0] got);
      testsRun++;
      if (got !== exp) begin
         nFail++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic tick;
      @(posedge clk_sys);
      #1;
   endtask
   task automatic waitCtl(input logic [13:0] exp);
      for (int t = 0; t < 1000 && controlWord !== exp; t++) tick;
      chk("controlWord", exp, controlWord);
   endtask
   // Release soft reset, time first output, measure step per cycle
   task automatic runFrom(input logic [15:0] ctl, input logic [11:0] step, output logic [11:0] first);
      int n;
      q = '{ctl};
      fork
         dds_host_model_inst.xfer(q, 16);
      join_none
      for (n = 0; n < 1000 && controlWord !== ctl[13:0]; n++) tick;
      for (n = 0; n < 50 && phaseOut === 12'h000; n++) tick;
      chk("latency", 14'h0008, 14'(n));
      first = phaseOut;
      tick;
      chk("step", {2'h0, step}, {2'h0, phaseOut - first});
      wait fork;
   endtask
   // ********
   // Scenarios
   // ********
   task automatic tResetValues;
      chk("controlWord", 14'h0000, controlWord);
      chk("phaseOut", 14'h0000, {2'h0, phaseOut});
      chk("loadReady", 14'h0001, {13'h0000, loadReady});
   endtask
   task automatic tFullWord;
      // Soft reset held while a whole frequency word goes in, low half first
      q = '{16'h2102, 16'h4000, 16'h4004};
      dds_host_model_inst.xfer(q, 16);
      waitCtl(14'h2102);
      chk("waveMode", 14'h0001, {13'h0000, waveMode});
      tick;
      chk("resetActive", 14'h0001, {13'h0000, resetActive});
      chk("phaseOut", 14'h0000, {2'h0, phaseOut});
      runFrom(16'h2000, 12'h001, p);
   endtask
   task automatic tHalfWord;
      // Upper half then lower half; lower write must keep the upper
      q = '{16'h1100, 16'h4008, 16'h0100, 16'h4001};
      dds_host_model_inst.xfer(q, 16);
      waitCtl(14'h0100);
      runFrom(16'h0000, 12'h002, p);
   endtask
   task automatic tSelect;
      q = '{16'h1100, 16'h8010, 16'he101};
      dds_host_model_inst.xfer(q, 16);
      runFrom(16'h0c00, 12'h004, p);
      chk("phaseLow", 14'h0001, {12'h000, p[1:0]});
   endtask
   task automatic tSleepReset;
      q = '{16'h0c80};
      dds_host_model_inst.xfer(q, 16);
      waitCtl(14'h0c80);
      tick;
      tick;
      p = phaseOut;
      repeat (6) tick;
      chk("phaseOut", {2'h0, p}, {2'h0, phaseOut});
      q = '{16'h0d00};
      dds_host_model_inst.xfer(q, 16);
      waitCtl(14'h0d00);
      repeat (10) tick;
      chk("phaseOut", 14'h0000, {2'h0, phaseOut});
      runFrom(16'h0c00, 12'h004, p);
   endtask
   task automatic tShortFrame;
      q = '{16'h0002};
      dds_host_model_inst.xfer(q, 9);
      repeat (60) tick;
      chk("controlWord", 14'h0c00, controlWord);
      dds_host_model_inst.xfer(q, 16);
      waitCtl(14'h0002);
      chk("loadReady", 14'h0001, {13'h0000, loadReady});
   endtask
   task automatic tFreeze;
      @(posedge clk_sys);
      clkEn <= 1'b0;
      tick;
      p = phaseOut;
      repeat (5) tick;
      chk("phaseOut", {2'h0, p}, {2'h0, phaseOut});
      @(posedge clk_sys);
      clkEn <= 1'b1;
   endtask
   initial begin
      rst_n <= 1'b0;
      clkEn <= 1'b1;
      nFail = 0;
      testsRun = 0;
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (5) tick;
      tResetValues;
      tFullWord;
      tHalfWord;
      tSelect;
      tSleepReset;
      tShortFrame;
      tFreeze;
      tallyAndFinish;
   end
   // Whole run needs about 37 us; allow a little over five times that
   initial begin
      #200000;
      nFail++;
      tallyAndFinish;
   end
endmodule
`default_nettype wire
